/* File: shared/msec_pkg.sv */
// constants for the serial monitor entry and security block
//
// How it works
// - monitor re-sends every received character
// - host sends eight bytes, expects double echo
// - break sent after eighth byte, pass or fail
// - reset cause msb set only after power-on
// - reset cause read leaves security untouched
// - security passes only after power-on reset
// - protected or invalid reads return AD hex
// - compare received bytes with FFF6 to FFFD
// - failed security still serves, hides memory
// - monitor entry needs mode pins at reset
package msec_pkg;
   // bus clock and serial bit timing
   localparam int          CLK_HZ         = 40000000;
   localparam int          BAUD           = 1000000;
   localparam int          BIT_CYC        = CLK_HZ / BAUD;
   localparam int          HALF_CYC       = BIT_CYC / 2;
   localparam int          BRK_BITS       = 12;
   localparam int          DATA_BITS      = 8;
   localparam int          SEC_BYTES      = 8;
   // monitor command codes and answers
   localparam logic [7:0]  CMD_READ       = 8'h4A;
   localparam logic [7:0]  CMD_WRITE      = 8'h49;
   localparam logic [7:0]  PROT_VAL       = 8'hAD;
   localparam logic [7:0]  MON_VERSION    = 8'h01;
   // memory map of the monitor's view
   localparam logic [15:0] VER_ADDR       = 16'hFE00;
   localparam logic [15:0] RSR_ADDR       = 16'hFE01;
   localparam logic [15:0] SEC_BASE       = 16'hFFF6;
   localparam logic [15:0] NVM_BASE       = 16'h8000;
   localparam logic [15:0] RAM_TOP        = 16'h0100;
   localparam int          RSR_POR_BIT    = 7;
   localparam int          RSR_PIN_BIT    = 6;
   // ahb-lite register map
   localparam logic [7:0]  REG_STATUS     = 8'h00;
   localparam logic [7:0]  REG_IRQ_STAT   = 8'h04;
   localparam logic [7:0]  REG_IRQ_MASK   = 8'h08;
   localparam logic [7:0]  REG_RST_CAUSE  = 8'h0C;
   localparam logic [7:0]  REG_CTRL       = 8'h10;
   localparam logic [7:0]  REG_NVM_ADDR   = 8'h14;
   localparam logic [7:0]  REG_NVM_DATA   = 8'h18;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam int          NVM_WORDS      = 256;
   localparam int          IRQ_W          = 4;
   // interrupt status bits
   localparam int          IRQ_BYTE       = 0;
   localparam int          IRQ_SEC_DONE   = 1;
   localparam int          IRQ_BRK_RX     = 2;
   localparam int          IRQ_FRAME      = 3;
   typedef enum logic [2:0] {MS_SEC, MS_BRK, MS_CMD, MS_ADH, MS_ADL, MS_REPLY, MS_USER} msec_mon_t;
endpackage

/* File: logic/msec_monitor.sv */
// serial monitor entry, security check and reset cause logic
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module msec_monitor
   import msec_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        por_i,
   input  wire logic        pin_rst_i,
   input  wire logic        irq_mode_pin_i,
   input  wire logic        mon_rx_i,
   output logic             mon_tx_o,
   output logic             mon_tx_oe_o,
   output logic             irq_o,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hsel_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o
);
   localparam int CW = 16;
   localparam logic [CW-1:0] BIT_N  = CW'(BIT_CYC - 1);
   localparam logic [CW-1:0] HALF_N = CW'(HALF_CYC - 1);

   // synchronisers for pins
   logic rx_s1_q, rx_q, irq_s1_q, irq_q, por_s1_q, por_q, pr_s1_q, pr_q;
   always_ff @(posedge mclk_i) begin
      rx_s1_q  <= mon_rx_i;
      rx_q     <= rx_s1_q;
      irq_s1_q <= irq_mode_pin_i;
      irq_q    <= irq_s1_q;
      por_s1_q <= por_i;
      por_q    <= por_s1_q;
      pr_s1_q  <= pin_rst_i;
      pr_q     <= pr_s1_q;
   end

   // receiver: start bit, eight data bits lsb first, stop; low stop after all-zero data is a break, else a framing error
   logic [CW-1:0] rx_cnt_q;
   logic [3:0]    rx_bit_q;
   logic [7:0]    rx_sh_q;
   logic          rx_busy_q, rx_vld_q, rx_brk_q, rx_ferr_q;
   always_ff @(posedge mclk_i) begin
      rx_vld_q  <= 1'b0;
      rx_brk_q  <= 1'b0;
      rx_ferr_q <= 1'b0;
      if (!rst_b_i) begin
         rx_busy_q <= 1'b0;
         rx_cnt_q  <= '0;
         rx_bit_q  <= '0;
         rx_sh_q   <= '0;
      end else if (!rx_busy_q) begin
         if (!rx_q) begin
            rx_busy_q <= 1'b1;
            rx_cnt_q  <= HALF_N;
            rx_bit_q  <= '0;
         end
      end else if (rx_cnt_q != '0) begin
         rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
         rx_cnt_q <= BIT_N;
         rx_bit_q <= rx_bit_q + 1'b1;
         if (rx_bit_q == 4'h0) begin
            if (rx_q) rx_busy_q <= 1'b0; // false start
         end else if (rx_bit_q <= 4'(DATA_BITS)) begin
            rx_sh_q <= {rx_q, rx_sh_q[7:1]};
         end else if (rx_bit_q == 4'(DATA_BITS + 1) && rx_q) begin
            rx_busy_q <= 1'b0;
            rx_vld_q  <= 1'b1;
         end else if (rx_bit_q == 4'(DATA_BITS + 1) && rx_sh_q == 8'h00) begin
            rx_bit_q <= 4'(DATA_BITS + 2); // all zero, low stop: break
         end else if (rx_bit_q == 4'(DATA_BITS + 1)) begin
            rx_ferr_q <= 1'b1;
            rx_bit_q  <= 4'(DATA_BITS + 3);
         end else begin
            rx_bit_q <= rx_bit_q; // hold low until the line rises
         end
      end
      // line high again after a low stop ends a break or a bad frame
      if (rst_b_i && rx_busy_q && rx_bit_q > 4'(DATA_BITS + 1) && rx_q) begin
         rx_busy_q <= 1'b0;
         rx_brk_q  <= (rx_bit_q == 4'(DATA_BITS + 2));
      end
   end

   // transmitter: one frame or a break of BRK_BITS low bit times
   logic [CW-1:0] tx_cnt_q;
   logic [3:0]    tx_bit_q;
   logic [9:0]    tx_sh_q;
   logic          tx_busy_q, tx_brk_q, tx_line_q;
   logic          tx_go, tx_go_brk;
   logic [7:0]    tx_byte;
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         tx_busy_q <= 1'b0;
         tx_brk_q  <= 1'b0;
         tx_line_q <= 1'b1;
         tx_cnt_q  <= '0;
         tx_bit_q  <= '0;
         tx_sh_q   <= '1;
      end else if (!tx_busy_q) begin
         tx_line_q <= 1'b1;
         if (tx_go || tx_go_brk) begin
            tx_busy_q <= 1'b1;
            tx_brk_q  <= tx_go_brk;
            tx_sh_q   <= tx_go_brk ? 10'h000 : {1'b1, tx_byte, 1'b0};
            tx_bit_q  <= '0;
            tx_cnt_q  <= BIT_N;
            tx_line_q <= 1'b0;
         end
      end else if (tx_cnt_q != '0) begin
         tx_cnt_q <= tx_cnt_q - 1'b1;
      end else begin
         tx_cnt_q <= BIT_N;
         tx_bit_q <= tx_bit_q + 1'b1;
         if (tx_brk_q) begin
            tx_line_q <= (tx_bit_q >= 4'(BRK_BITS - 1));
            if (tx_bit_q == 4'(BRK_BITS)) tx_busy_q <= 1'b0;
         end else begin
            tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
            tx_line_q <= tx_sh_q[1];
            if (tx_bit_q == 4'(DATA_BITS + 1)) tx_busy_q <= 1'b0;
         end
      end
   end

   // one-deep pending reply so the echo is never lost
   logic       pend_q;
   logic [7:0] pend_byte_q;
   logic       want;
   logic [7:0] want_byte;
   assign tx_go   = pend_q && !tx_busy_q && !tx_go_brk;
   assign tx_byte = pend_byte_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         pend_q      <= 1'b0;
         pend_byte_q <= '0;
      end else if (want) begin
         pend_q      <= 1'b1;
         pend_byte_q <= want_byte;
      end else if (tx_go) begin
         pend_q <= 1'b0;
      end
   end

   // reset cause captured at release of reset
   logic       rst_seen_q;
   logic [7:0] rsr_q;
   logic       por_hold_q, pin_hold_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         rst_seen_q <= 1'b0;
         rsr_q      <= '0;
      end else if (!rst_seen_q) begin
         rst_seen_q               <= 1'b1;
         rsr_q                    <= '0;
         rsr_q[RSR_POR_BIT]       <= por_q;
         rsr_q[RSR_PIN_BIT]       <= pr_q && !por_q;
      end
   end
   assign por_hold_q = rsr_q[RSR_POR_BIT];
   assign pin_hold_q = rsr_q[RSR_PIN_BIT];

   // non-volatile array, written by software over the bus
   logic [7:0] nvm_mem [NVM_WORDS];
   logic [7:0] nvm_wa_q;
   logic       nvm_we;
   logic [7:0] nvm_wd;

   // monitor sequence
   msec_mon_t  st_q;
   logic [3:0] sec_n_q;
   logic       sec_ok_q, unlocked_q;
   logic [15:0] addr_q;
   logic [7:0] rd_val;
   logic       nvm_hit;
   always_comb begin
      nvm_hit = addr_q >= NVM_BASE;
      if (addr_q == VER_ADDR) rd_val = MON_VERSION;
      else if (addr_q == RSR_ADDR) rd_val = rsr_q;
      else if (nvm_hit && unlocked_q) rd_val = nvm_mem[addr_q[7:0]];
      else rd_val = PROT_VAL;
   end
   always_comb begin
      want      = 1'b0;
      want_byte = rx_sh_q;
      if (st_q != MS_USER && rx_vld_q) want = 1'b1;
      if (st_q == MS_REPLY && !pend_q && !tx_busy_q && !rx_vld_q) begin
         want      = 1'b1;
         want_byte = rd_val;
      end
   end
   assign tx_go_brk = (st_q == MS_BRK) && !tx_busy_q && !pend_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         st_q       <= MS_SEC;
         sec_n_q    <= '0;
         sec_ok_q   <= 1'b1;
         unlocked_q <= 1'b0;
         addr_q     <= '0;
      end else begin
         case (st_q)
            MS_SEC: begin
               if (rst_seen_q && !irq_q && sec_n_q == '0) st_q <= MS_USER;
               else if (rx_vld_q) begin
                  if (rx_sh_q != nvm_mem[SEC_BASE[7:0] + 8'(sec_n_q)]) sec_ok_q <= 1'b0;
                  sec_n_q <= sec_n_q + 1'b1;
                  if (sec_n_q == 4'(SEC_BYTES - 1)) st_q <= MS_BRK;
               end
            end
            MS_BRK: begin
               if (tx_go_brk) begin
                  st_q       <= MS_CMD;
                  unlocked_q <= sec_ok_q && por_hold_q;
               end
            end
            MS_CMD:   if (rx_vld_q && rx_sh_q == CMD_READ) st_q <= MS_ADH;
            MS_ADH:   if (rx_vld_q) begin addr_q[15:8] <= rx_sh_q; st_q <= MS_ADL; end
            MS_ADL:   if (rx_vld_q) begin addr_q[7:0] <= rx_sh_q; st_q <= MS_REPLY; end
            MS_REPLY: if (want && !rx_vld_q) st_q <= MS_CMD;
            default:  st_q <= MS_USER;
         endcase
      end
   end

   // serial pin drive: enable held while the transmitter is busy, high bits included
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         mon_tx_o    <= 1'b1;
         mon_tx_oe_o <= 1'b0;
      end else begin
         mon_tx_o    <= tx_line_q;
         mon_tx_oe_o <= tx_busy_q;
      end
   end

   // interrupt events, status sticky with write-one-to-clear, set wins
   logic [IRQ_W-1:0] ev, ist_q, imsk_q, w1c;
   assign ev = {rx_ferr_q, rx_brk_q, tx_go_brk, rx_vld_q};
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) ist_q <= '0;
      else ist_q <= (ist_q & ~w1c) | ev;
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) irq_o <= 1'b0;
      else irq_o <= |(ist_q & imsk_q);
   end

   // ahb-lite slave, zero wait states
   logic       ph_q, ph_wr_q;
   logic [7:0] ph_a_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         ph_q    <= 1'b0;
         ph_wr_q <= 1'b0;
         ph_a_q  <= '0;
      end else if (hready_i) begin
         ph_q    <= hsel_i && htrans_i[1];
         ph_wr_q <= hwrite_i;
         ph_a_q  <= haddr_i[7:0];
      end
   end
   logic wr;
   assign wr     = ph_q && ph_wr_q;
   assign w1c    = (wr && ph_a_q == REG_IRQ_STAT) ? hwdata_i[IRQ_W-1:0] : '0;
   assign nvm_we = wr && ph_a_q == REG_NVM_DATA;
   assign nvm_wd = hwdata_i[7:0];
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         imsk_q   <= '0;
         nvm_wa_q <= '0;
      end else if (wr) begin
         if (ph_a_q == REG_IRQ_MASK) imsk_q <= hwdata_i[IRQ_W-1:0];
         else if (ph_a_q == REG_NVM_ADDR) nvm_wa_q <= hwdata_i[7:0];
         else if (ph_a_q == REG_NVM_DATA) nvm_wa_q <= nvm_wa_q + 1'b1;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (nvm_we) nvm_mem[nvm_wa_q] <= nvm_wd;
   end
   // read data registered at the address phase
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) hrdata_o <= '0;
      else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
         if (haddr_i[7:0] == REG_STATUS)
            hrdata_o <= {20'h0, sec_n_q, 1'b0, st_q, unlocked_q, sec_ok_q, pend_q, tx_busy_q};
         else if (haddr_i[7:0] == REG_IRQ_STAT) hrdata_o <= {28'h0, ist_q};
         else if (haddr_i[7:0] == REG_IRQ_MASK) hrdata_o <= {28'h0, imsk_q};
         else if (haddr_i[7:0] == REG_RST_CAUSE) hrdata_o <= {24'h0, rsr_q};
         else if (haddr_i[7:0] == REG_NVM_ADDR) hrdata_o <= {24'h0, nvm_wa_q};
         else hrdata_o <= '0;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end
   logic unused;
   assign unused = ^{hsize_i, pin_hold_q, haddr_i[31:8]};
endmodule
`default_nettype wire

/* File: verification/msec_monitor_checker.sv */
// port checker for the monitor entry and security block
`timescale 1ns/10ps
`default_nettype none
module msec_monitor_checker
   import msec_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        rst_b_i,
   input wire logic        irq_mode_pin_i,
   input wire logic        mon_tx_o,
   input wire logic        mon_tx_oe_o,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic        hsel_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o
);
   logic [31:0] low_q;
   logic        mode_q;
   wire         rd_take = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // length of the running low stretch on the transmit line
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i || mon_tx_o) begin
         low_q <= 32'h0;
      end else begin
         low_q <= low_q + 32'h1;
      end
   end
   // mode level as it stood through reset
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         mode_q <= irq_mode_pin_i;
      end
   end
   // end of a low stretch, and one too long to be a data frame
   sequence s_low_end; $rose(mon_tx_o); endsequence
   sequence s_long_low; s_low_end ##0 (low_q > 9 * BIT_CYC + HALF_CYC); endsequence
   property p_idle_high; !mon_tx_oe_o |-> mon_tx_o; endproperty
   property p_drive_low; $fell(mon_tx_o) |-> mon_tx_oe_o; endproperty
   property p_bit_min; s_low_end |-> low_q >= BIT_CYC - 1; endproperty
   property p_break_len; s_long_low |-> low_q >= 10 * BIT_CYC; endproperty
   property p_user_silent; !mode_q |-> !mon_tx_oe_o; endproperty
   property p_zero_wait; hsel_i |-> hreadyout_o; endproperty
   property p_okay; hsel_i |-> !hresp_o; endproperty
   property p_rd_hold; !$stable(hrdata_o) |-> $past(rd_take); endproperty
   a_idle_high: assert property (p_idle_high) else $error("line low while released");
   a_drive_low: assert property (p_drive_low) else $error("start bit not driven");
   a_bit_min: assert property (p_bit_min) else $error("low pulse under one bit");
   a_break_len: assert property (p_break_len) else $error("break too short");
   a_user_silent: assert property (p_user_silent) else $error("user mode transmits");
   a_zero_wait: assert property (p_zero_wait) else $error("wait state inserted");
   a_okay: assert property (p_okay) else $error("response not okay");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
endmodule
bind msec_monitor msec_monitor_checker u_chk (.mclk_i, .rst_b_i, .irq_mode_pin_i,
   .mon_tx_o, .mon_tx_oe_o, .htrans_i, .hwrite_i, .hsel_i, .hready_i, .hrdata_o,
   .hreadyout_o, .hresp_o);
`default_nettype wire

/* File: verification/msec_host_model.sv */
// host debugger model on the half-duplex monitor line
`timescale 1ns/10ps
`default_nettype none
module msec_host_model
   import msec_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic mon_tx_i,
   input  wire logic mon_tx_oe_i,
   output logic      mon_rx_o
);
   // host hears its own loopback and the target; pulled up when idle
   wire line_w = mon_rx_o & (mon_tx_oe_i ? mon_tx_i : 1'b1);
   initial mon_rx_o = 1'b1;
   // one frame: start, data lsb first, one or two stop bits
   task automatic send(input logic [7:0] b, input int nstop);
      logic [10:0] f;
      f = {2'b11, b, 1'b0};
      for (int i = 0; i < 9 + nstop; i++) begin
         @(posedge mclk_i) mon_rx_o <= f[i];
         repeat (BIT_CYC - 1) @(posedge mclk_i);
      end
   endtask
   // receive one frame; a low stop bit marks a break and its length
   task automatic recv(output logic [7:0] b, output int low_len, output logic ok);
      int n;
      b = 8'h00;
      ok = 1'b0;
      low_len = 0;
      for (n = 0; n < 24 * BIT_CYC && line_w !== 1'b0; n++) @(posedge mclk_i);
      if (n >= 24 * BIT_CYC) return;
      repeat (HALF_CYC) @(posedge mclk_i);
      for (int i = 0; i < DATA_BITS; i++) begin
         repeat (BIT_CYC) @(posedge mclk_i);
         b[i] = line_w;
      end
      repeat (BIT_CYC) @(posedge mclk_i);
      ok = line_w;
      for (n = 0; n < 20 * BIT_CYC && line_w !== 1'b1; n++) @(posedge mclk_i);
      low_len = 9 * BIT_CYC + HALF_CYC + n;
   endtask
   // one byte out; loopback copy first, then the monitor copy
   task automatic echo(input logic [7:0] b, input int nstop, output logic good);
      logic [7:0] l1, l2;
      logic       k1, k2;
      int         len;
      fork
         send(b, nstop);
      join_none
      recv(l1, len, k1);
      recv(l2, len, k2);
      good = k1 & k2 & (l1 === b) & (l2 === b);
   endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench: security sessions, monitor reads, registers
`timescale 1ns/10ps
`default_nettype none
module tb;
   import msec_pkg::*;
   logic        mclk_i = 1'b0;
   logic        rst_b_i, por_i, pin_rst_i, irq_mode_pin_i, mon_rx_i, mon_tx_o;
   logic        mon_tx_oe_o, irq_o, hwrite_i, hsel_i, hreadyout_o, hresp_o;
   logic [1:0]  htrans_i;
   logic [2:0]  hsize_i;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
   logic [7:0]  key [8];
   int          num_errors = 0;
   int          tests_run = 0;
   msec_monitor dut (.mclk_i, .rst_b_i, .por_i, .pin_rst_i, .irq_mode_pin_i, .mon_rx_i,
      .mon_tx_o, .mon_tx_oe_o, .irq_o, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
      .hwdata_i, .hsel_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o);
   msec_host_model host (.mclk_i, .mon_tx_i(mon_tx_o), .mon_tx_oe_i(mon_tx_oe_o),
      .mon_rx_o(mon_rx_i));
   // bus clock
   always #12.5 mclk_i = ~mclk_i;
   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   // counts and verdict
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // one single-word transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_i);
      haddr_i <= {24'h000000, a};
      htrans_i <= HTRANS_NONSEQ;
      hwrite_i <= wr;
      for (n = 0; n < 64; n++) begin
         @(posedge mclk_i);
         if (hreadyout_o === 1'b1) break;
      end
      htrans_i <= 2'h0;
      hwdata_i <= d;
      for (n = n; n < 64; n++) begin
         @(posedge mclk_i);
         if (hreadyout_o === 1'b1) break;
      end
      rd = hrdata_o;
      if (n >= 64) begin
         check(32'h1, 32'h0, "bus timeout");
         close_out();
      end
   endtask
   // bounded wait for the interrupt level
   task automatic wait_irq(input logic v);
      int n;
      for (n = 0; n < 8 && irq_o !== v; n++) @(posedge mclk_i);
      check(irq_o, v, "interrupt level");
   endtask
   // monitor read: command and address bytes echoed, then one reply
   task automatic mon_read(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] c [3];
      logic       ok;
      int         len;
      c = '{CMD_READ, a[15:8], a[7:0]};
      for (int i = 0; i < 3; i++) begin
         host.echo(c[i], 2, ok);
         check(ok, 32'h1, "command echo");
      end
      host.recv(c[0], len, ok);
      check({ok, c[0]}, {1'b1, exp}, "monitor reply");
   endtask
   // reset with a given cause and mode, program the key, run one entry
   task automatic session(input logic p, input logic m, input logic good);
      logic       ok;
      logic [7:0] b;
      int         len;
      @(posedge mclk_i);
      rst_b_i <= 1'b0;
      por_i <= p;
      pin_rst_i <= ~p;
      irq_mode_pin_i <= m;
      repeat (8) @(posedge mclk_i);
      check({mon_tx_o, mon_tx_oe_o, irq_o, hreadyout_o}, 32'h9, "reset state");
      rst_b_i <= 1'b1;
      bus(1'b1, REG_NVM_ADDR, 32'h000000F6);
      for (int i = 0; i < SEC_BYTES; i++) bus(1'b1, REG_NVM_DATA, {24'h000000, key[i]});
      bus(1'b0, REG_RST_CAUSE, 32'h0);
      check(rd[7:6], {p, ~p}, "reset cause");
      for (int i = 0; i < (m ? SEC_BYTES : 1); i++) begin
         host.echo(key[i] ^ {7'h00, i == 7 && !good}, 1, ok);
         check(ok, m, "double echo");
      end
      if (m) begin
         host.recv(b, len, ok);
         check({ok, b}, 32'h0, "break not data");
         check(len >= 10 * BIT_CYC, 32'h1, "break length");
         mon_read(VER_ADDR, MON_VERSION);
         mon_read(RSR_ADDR, {p, ~p, 6'h00});
         mon_read(SEC_BASE, (p && good) ? key[0] : PROT_VAL);
         bus(1'b0, REG_STATUS, 32'h0);
         check(rd[3], p && good, "unlock state");
      end
   endtask
   // main sequence
   initial begin
      rst_b_i = 1'b0;
      por_i = 1'b1;
      pin_rst_i = 1'b0;
      irq_mode_pin_i = 1'b1;
      hwrite_i = 1'b0;
      hsel_i = 1'b1;
      htrans_i = 2'h0;
      hsize_i = 3'h2;
      haddr_i = 32'h0;
      hwdata_i = 32'h0;
      key = '{8'h3C, 8'hA5, 8'h00, 8'hFF, 8'h5A, 8'h81, 8'h7E, 8'h12};
      session(1'b1, 1'b1, 1'b1);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      check(rd[3:0], 32'h3, "event status");
      bus(1'b1, REG_IRQ_MASK, 32'h0);
      wait_irq(1'b0);
      bus(1'b1, REG_IRQ_MASK, 32'h2);
      wait_irq(1'b1);
      bus(1'b1, REG_IRQ_STAT, 32'h2);
      wait_irq(1'b0);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      check(rd[3:0], 32'h1, "one bit cleared");
      bus(1'b0, 8'h1C, 32'h0);
      check(rd, 32'h0, "unmapped read");
      session(1'b0, 1'b1, 1'b1);
      session(1'b1, 1'b1, 1'b0);
      session(1'b1, 1'b0, 1'b1);
      close_out();
   end
endmodule
`default_nettype wire
